//--- rtl/dpot_host.sv
// Serial controller end: APB registers and a divider-made shift clock of 250/26 MHz, just under 10 MHz
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module dpot_host
  import dpot_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  dpot_if.host             link
);
  import dpot_pkg::*;

  dpot_state_t          state_r;
  logic [WORD_BITS-1:0] word_r;
  logic [3:0]           bit_r;
  logic [4:0]           div_r;
  logic [1:0]           ctrl_r;
  logic                 sclk_r;
  logic                 cs_n_r;
  logic                 sdi_r;
  logic [31:0]          prdata_r;
  logic                 err_r;
  logic                 wr_cmd;

  assign wr_cmd  = psel && penable && pwrite && paddr == REG_CMD && state_r == ST_IDLE;
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = err_r;

  // Read data and error for unmapped addresses, settled in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
      err_r    <= 1'b0;
    end else if (psel && !penable) begin
      err_r    <= !(paddr == REG_CMD || paddr == REG_STATUS || paddr == REG_CTRL);
      case (paddr)
        REG_CMD:    prdata_r <= {22'h0, word_r};
        REG_STATUS: prdata_r <= {31'h0, state_r != ST_IDLE};
        REG_CTRL:   prdata_r <= {30'h0, ctrl_r};
        default:    prdata_r <= 32'h0;
      endcase
    end
  end

  // Reset and shutdown pin levels; reset bit is active-high in software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 2'h0;
    end else if (psel && penable && pwrite && paddr == REG_CTRL) begin
      ctrl_r <= pwdata[1:0];
    end
  end

  // Word send: cs low, ten clocks MSB first, then cs high to load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      word_r  <= 10'h0;
      bit_r   <= 4'h0;
      div_r   <= 5'h0;
      sclk_r  <= 1'b0;
      cs_n_r  <= 1'b1;
      sdi_r   <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (wr_cmd) begin
            word_r  <= pwdata[WORD_BITS-1:0];          // see [RULE1] see [RULE4]
            cs_n_r  <= 1'b0;
            sdi_r   <= pwdata[WORD_BITS-1];            // see [RULE2]
            bit_r   <= 4'h0;
            div_r   <= 5'h0;
            state_r <= ST_LOW;
          end
        end
        ST_LOW: begin
          div_r <= div_r + 5'h1;
          if (div_r == 5'(SCLK_HALF - 1)) begin       // see [RULE14]
            div_r   <= 5'h0;
            sclk_r  <= 1'b1;                           // see [RULE15]
            state_r <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          div_r <= div_r + 5'h1;
          if (div_r == 5'(SCLK_HALF - 1)) begin
            div_r  <= 5'h0;
            sclk_r <= 1'b0;
            bit_r  <= bit_r + 4'h1;
            word_r <= {word_r[WORD_BITS-2:0], 1'b0};
            sdi_r  <= word_r[WORD_BITS-2];
            state_r <= (bit_r == 4'(WORD_BITS - 1)) ? ST_DESEL : ST_LOW;
          end
        end
        ST_DESEL: begin
          div_r <= div_r + 5'h1;
          if (div_r == 5'(SCLK_HALF - 1)) begin
            cs_n_r  <= 1'b1;                           // see [RULE16]
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign link.sclk             = sclk_r;
  assign link.cs_n             = cs_n_r;
  assign link.serial_in        = sdi_r;
  assign link.midscale_reset_n = !ctrl_r[CTRL_RST];
  assign link.power_down_n     = !ctrl_r[CTRL_PDN];
endmodule
`default_nettype wire

//--- rtl/dpot_pkg.sv
// Shared constants for the digital potentiometer serial link
package dpot_pkg;
  localparam int          WORD_BITS   = 10;
  localparam int          ADDR_BITS   = 2;
  localparam int          DATA_BITS   = 8;
  localparam int          NUM_CHAN    = 4;
  localparam logic [7:0]  MIDSCALE    = 8'h80;
  localparam int          PCLK_MHZ    = 250;
  localparam int          SCLK_MHZ    = 10;
  // Divider half period in pclk cycles, rounded up so the link stays at or below 10 MHz
  localparam int          SCLK_HALF   = (PCLK_MHZ + 2 * SCLK_MHZ - 1) / (2 * SCLK_MHZ);
  // Controller register byte addresses
  localparam logic [7:0]  REG_CMD     = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_CTRL    = 8'h08;
  localparam int          ST_BUSY     = 0;
  localparam int          CTRL_RST    = 0;
  localparam int          CTRL_PDN    = 1;
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_DESEL} dpot_state_t;
endpackage

//--- rtl/dpot_if.sv
// Link between the serial controller and the potentiometer
`timescale 1ns/10ps
`default_nettype none
interface dpot_if;
  logic sclk;
  logic cs_n;
  logic serial_in;
  logic chain_out_o;
  logic chain_out_oe;
  logic midscale_reset_n;
  logic power_down_n;
  // Open-drain pin: pulled high unless driven low
  wire  chain_out = chain_out_oe ? chain_out_o : 1'b1;
  modport device (input sclk, input cs_n, input serial_in, input midscale_reset_n, input power_down_n,
                  output chain_out_o, output chain_out_oe);
  modport host   (output sclk, output cs_n, output serial_in, output midscale_reset_n, output power_down_n,
                  input chain_out);
endinterface
`default_nettype wire

//--- rtl/dpot_device.sv
// Potentiometer end: serial shift register, wiper latches, shutdown and chain output
// Behaviour
// [RULE1] One ten-bit word per setting update
// [RULE2] Two address bits then eight data, MSB first
// [RULE3] Channel is two times upper plus lower plus one
// [RULE4] Host zeroes unused address bits on small variants
// [RULE5] Channels update singly, in any order
// [RULE6] Latches need no power-up preset
// [RULE7] Reset input forces latches to midscale
// [RULE8] Shutdown opens A, ties wiper to B
// [RULE9] Shutdown keeps every latch value
// [RULE10] Shutdown keeps input, disables chain output
// [RULE11] Latch writes accepted during shutdown
// [RULE12] Eight-bit code selects one of 256 taps
// [RULE13] Code 0 at B, 255 full scale
// [RULE14] Shift clock up to 10 MHz supported
// [RULE15] Shift one bit per rising clock while selected
// [RULE16] Select rising edge loads addressed latch
// [RULE17] Reset sets latches 80h, clears chain latch
// [RULE18] Chain output gives bit from ten edges earlier
`timescale 1ns/10ps
`default_nettype none
module dpot_device
  import dpot_pkg::*;
#(
  parameter int NCH = dpot_pkg::NUM_CHAN
) (
  dpot_if.device                       link,
  output logic [dpot_pkg::DATA_BITS-1:0] wiper_tap [NCH],
  output logic                         a_open,
  output logic                         wiper_to_b
);
  import dpot_pkg::*;

  logic [WORD_BITS-1:0] shift_r;
  logic                 chain_r;
  logic [DATA_BITS-1:0] wiper_latch [NCH];

  // Shift register on the link clock; reset clears only the chain latch
  always_ff @(posedge link.sclk or negedge link.midscale_reset_n) begin
    if (!link.midscale_reset_n) begin
      chain_r <= 1'b0;                                 // see [RULE17]
    end else if (!link.cs_n) begin
      chain_r <= shift_r[WORD_BITS-1];                 // see [RULE18]
    end
  end

  // Shifting keeps running in shutdown so codes can be staged
  always_ff @(posedge link.sclk) begin
    if (!link.cs_n) begin
      shift_r <= {shift_r[WORD_BITS-2:0], link.serial_in}; // see [RULE15] see [RULE1] see [RULE10]
    end
  end

  // Latches load on select rising edge; no power-up preset without reset
  always_ff @(posedge link.cs_n or negedge link.midscale_reset_n) begin
    if (!link.midscale_reset_n) begin
      for (int i = 0; i < NCH; i++) begin
        wiper_latch[i] <= MIDSCALE;                    // see [RULE7] see [RULE17] see [RULE6]
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        // Address is upper*2+lower, channel numbering one-based outside
        if (shift_r[WORD_BITS-1 -: ADDR_BITS] == ADDR_BITS'(i)) begin // see [RULE3] see [RULE2] see [RULE16]
          wiper_latch[i] <= shift_r[DATA_BITS-1:0];    // see [RULE5] see [RULE11]
        end
      end
    end
  end

  // Outputs: tap index equals code, 0 at B end; shutdown leaves latches alone
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      wiper_tap[i] = wiper_latch[i];                   // see [RULE12] see [RULE13] see [RULE9]
    end
    a_open            = !link.power_down_n;            // see [RULE8]
    wiper_to_b        = !link.power_down_n;            // see [RULE8]
    link.chain_out_o  = 1'b0;
    // Open drain pulls low only for a zero, and stays off in shutdown
    link.chain_out_oe = link.power_down_n && !chain_r; // see [RULE10] see [RULE18]
  end
endmodule
`default_nettype wire

//--- verification/dpot_link_sva.sv
// Protocol checker on the wires between controller and potentiometer
`timescale 1ns/10ps
`default_nettype none
module dpot_link_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic chain_out_oe,
  input wire logic midscale_reset_n,
  input wire logic power_down_n,
  input wire logic chain_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] rises_r;
  logic [3:0] tot_r;
  logic [9:0] hist_r;
  logic       pop_r;
  // Shadow of the device shift register; tot_r saturates so early X bits are never judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rises_r <= 4'h0;
      tot_r   <= 4'h0;
      hist_r  <= 10'h0;
      pop_r   <= 1'b0;
    end else begin
      rises_r <= cs_n ? 4'h0 : rises_r + 4'($rose(sclk));
      if ($rose(sclk) && !cs_n) begin
        hist_r <= {hist_r[8:0], serial_in};
        pop_r  <= hist_r[9];
        tot_r  <= (tot_r == 4'ha) ? tot_r : tot_r + 4'h1;
      end
    end
  end
  sequence s_shift; $rose(sclk) && !cs_n; endsequence
  property p_pdn; !power_down_n |-> !chain_out_oe; endproperty
  a_pdn: assert property (p_pdn) else $error("chain output driven in shutdown");
  property p_idle; cs_n |-> !sclk; endproperty
  a_idle: assert property (p_idle) else $error("clock moved while deselected");
  property p_data; $rose(sclk) |-> $stable(serial_in); endproperty
  a_data: assert property (p_data) else $error("data moved at clock rise");
  property p_high; $rose(sclk) |-> sclk [*8]; endproperty
  a_high: assert property (p_high) else $error("clock high phase too short");
  property p_setup; $fell(cs_n) |-> !sclk [*8]; endproperty
  a_setup: assert property (p_setup) else $error("clock rose too soon after select");
  property p_count; $rose(cs_n) |-> rises_r == 4'ha; endproperty
  a_count: assert property (p_count) else $error("frame not ten bits");
  property p_mid; !midscale_reset_n && power_down_n |-> !chain_out; endproperty
  a_mid: assert property (p_mid) else $error("chain latch not cleared");
  property p_chain; s_shift ##0 (tot_r == 4'ha && power_down_n && midscale_reset_n) |-> ##2 chain_out == pop_r;
  endproperty
  a_chain: assert property (p_chain) else $error("chain output wrong bit");
endmodule
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench: controller and potentiometer joined over the link
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dpot_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, a_open, wiper_to_b;
  logic [7:0] paddr, etap [4], tap [4];
  logic [31:0] pwdata, prdata, rd, seed;
  logic err;
  int bad_count, checks, k, n;
  dpot_if lnk ();
  dpot_host dpot_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk));
  dpot_device dpot_device_i (.link(lnk), .wiper_tap(tap), .a_open(a_open), .wiper_to_b(wiper_to_b));
  dpot_link_sva dpot_link_sva_i (.pclk(pclk), .presetn(presetn), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
    .serial_in(lnk.serial_in), .chain_out_oe(lnk.chain_out_oe), .midscale_reset_n(lnk.midscale_reset_n),
    .power_down_n(lnk.power_down_n), .chain_out(lnk.chain_out));
  // Free-running 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  function automatic logic [31:0] word(logic [1:0] a, logic [7:0] d);
    return {22'h0, a, d};
  endfunction
  // Send one word, poll busy with a bound, then compare every latch with the model
  task automatic send(logic [1:0] a, logic [7:0] d);
    apb(1'b1, REG_CMD, word(a, d));
    etap[a] = d;
    // A second command while the word is still shifting must be ignored
    apb(1'b1, REG_CMD, word(~a, ~d));
    n = 0;
    do begin apb(1'b0, REG_STATUS, 32'h0); n++; end while (rd[ST_BUSY] !== 1'b0 && n < 500);
    if (n >= 500) bad_count++;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 4; i++) chk("tap", etap[i], tap[i]);
  endtask
  task automatic wrap_up;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    wrap_up;
  end
  initial begin
    seed = 32'h633c3962;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b1, REG_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin etap[i] = MIDSCALE; chk("mid", MIDSCALE, tap[i]); end
    $display("test midscale done");
    // Corner codes first, then random channels in random order
    for (k = 0; k < 12; k++) send(2'($random(seed)), k == 0 ? 8'h00 : k == 1 ? 8'hff : 8'($random(seed)));
    $display("test words done");
    apb(1'b1, REG_CTRL, 32'h2);
    // Pin levels settle only after the edge at which the write lands
    @(posedge pclk);
    chk("a_open", 8'h1, {7'h0, a_open});
    chk("to_b", 8'h1, {7'h0, wiper_to_b});
    chk("chain", 8'h1, {7'h0, lnk.chain_out});
    send(2'($random(seed)), 8'($random(seed)));
    apb(1'b1, REG_CTRL, 32'h0);
    @(posedge pclk);
    chk("a_open", 8'h0, {7'h0, a_open});
    chk("to_b", 8'h0, {7'h0, wiper_to_b});
    for (int i = 0; i < 4; i++) chk("tap", etap[i], tap[i]);
    $display("test shutdown done");
    apb(1'b0, 8'h0c, 32'h0);
    chk("err", 8'h1, {7'h0, err});
    chk("rd", 8'h0, rd[7:0]);
    $display("test unmapped done");
    wrap_up;
  end
endmodule
`default_nettype wire
